// >>> src/page_grain_cfg.svh
// Register numbers, field positions, reset values for the page granularity block.
`ifndef PAGE_GRAIN_CFG_SVH
`define PAGE_GRAIN_CFG_SVH

// Coprocessor register numbers and selects.
`define CP_NUM_XLATE_EVEN 5'h02
`define CP_NUM_XLATE_ODD 5'h03
`define CP_NUM_PAGE_SIZE 5'h05
`define CP_NUM_MATCH_HIGH 5'h0a
`define CP_NUM_CONFIG 5'h10
`define CP_SEL_XLATE 3'h0
`define CP_SEL_PAGE_SIZE 3'h0
`define CP_SEL_GRAIN 3'h1
`define CP_SEL_MATCH_HIGH 3'h0
`define CP_SEL_CONFIG_THREE 3'h3

// Granularity register fields.
`define GRAIN_READ_EN_BIT 31
`define GRAIN_EXEC_EN_BIT 30
`define GRAIN_MASK_HI 12
`define GRAIN_MASK_LO 11
`define GRAIN_ONES_HI 10
`define GRAIN_ONES_LO 8
`define GRAIN_MASK_RESET 2'h3
`define GRAIN_ONES_VALUE 3'h7

// Translation-low inhibit bit positions.
`define XLATE_READ_BLOCK_BIT 31
`define XLATE_EXEC_BLOCK_BIT 30

// Page-size select mask field, bits 24:11.
`define PSZ_HI 24
`define PSZ_LO 11
`define PSZ_WIDTH 14

// Match-high fields.
`define VPP_HI 31
`define VPP_LO 11
`define VPP_WIDTH 21
`define TAG_HI 7
`define TAG_LO 0

// Configuration word three: feature-present flag.
`define CFG3_PRESENT_BIT 1
`define CFG3_OTHER_DEFAULT 32'h0000_0000

`endif

// >>> src/page_grain_pkg.sv
// Types shared by the page granularity block.
`default_nettype none
package page_grain_pkg;
  typedef logic [4:0] cp_num_t;
  typedef logic [2:0] cp_sel_t;
  typedef logic [31:0] cp_word_t;
  typedef logic [1:0] grain_mask_t;
  typedef logic [13:0] psz_mask_t;
  typedef logic [20:0] vpp_t;
  typedef logic [7:0] tag_t;
endpackage
`default_nettype wire

// >>> src/page_grain_ctl.sv
// Page granularity configuration, match-high, page-size select and config word three.
`include "page_grain_cfg.svh"
`default_nettype none
module page_grain_ctl #(
  parameter bit IMPL_1K = 1'b1,
  parameter bit IMPL_2K = 1'b1
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Coprocessor move port
  input wire logic cp_wr_in,
  input wire logic cp_rd_in,
  input wire page_grain_pkg::cp_num_t cp_num_in,
  input wire page_grain_pkg::cp_sel_t cp_sel_in,
  input wire page_grain_pkg::cp_word_t cp_wdata_in,
  output page_grain_pkg::cp_word_t cp_rdata_out,
  output logic cp_rvalid_out,
  // Hardware loads from the TLB side
  input wire logic tlb_exc_in,
  input wire page_grain_pkg::cp_word_t exc_vaddr_in,
  input wire logic tlb_read_in,
  input wire page_grain_pkg::vpp_t tlb_rd_vpp_in,
  input wire page_grain_pkg::tag_t tlb_rd_tag_in,
  input wire page_grain_pkg::psz_mask_t tlb_rd_psz_in,
  // Translation controls toward the TLB
  output page_grain_pkg::psz_mask_t match_mask_out,
  output page_grain_pkg::vpp_t virt_page_pair_number_out,
  output page_grain_pkg::tag_t addr_space_tag_out,
  output page_grain_pkg::grain_mask_t grain_mask_out,
  output logic read_block_enable_out,
  output logic exec_block_enable_out,
  output logic [1:0] read_block_bit_out,
  output logic [1:0] exec_block_bit_out
);
  import page_grain_pkg::*;

  logic rst_meta_reg;
  logic rst_n;
  logic read_block_enable_reg;
  logic exec_block_enable_reg;
  grain_mask_t grain_reg;
  grain_mask_t grain_next;
  grain_mask_t load_mask;
  psz_mask_t psz_reg;
  vpp_t vpp_reg;
  tag_t tag_reg;
  logic [1:0] rb_bit_reg;
  logic [1:0] eb_bit_reg;
  logic wr_grain;
  logic wr_psz;
  logic wr_mh;
  logic [1:0] wr_xlate;
  cp_word_t rdata_next;

  // Reset release is synchronised so every flop leaves reset on the same edge.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  assign wr_grain = cp_wr_in && cp_num_in == `CP_NUM_PAGE_SIZE && cp_sel_in == `CP_SEL_GRAIN;
  assign wr_psz = cp_wr_in && cp_num_in == `CP_NUM_PAGE_SIZE && cp_sel_in == `CP_SEL_PAGE_SIZE;
  assign wr_mh = cp_wr_in && cp_num_in == `CP_NUM_MATCH_HIGH && cp_sel_in == `CP_SEL_MATCH_HIGH;
  assign wr_xlate[0] = cp_wr_in && cp_num_in == `CP_NUM_XLATE_EVEN && cp_sel_in == `CP_SEL_XLATE;
  assign wr_xlate[1] = cp_wr_in && cp_num_in == `CP_NUM_XLATE_ODD && cp_sel_in == `CP_SEL_XLATE;

  always_comb begin
    grain_next[0] = IMPL_1K ? cp_wdata_in[`GRAIN_MASK_LO] : 1'b1;
    if (IMPL_2K) begin
      grain_next[1] = cp_wdata_in[`GRAIN_MASK_HI];
    end else begin
      grain_next[1] = grain_next[0];
    end
  end

  // A load that meets a granularity write must honour the new mask, or
  // an overridden page-pair bit could be left holding a one.
  // Mask for loads.
  assign load_mask = wr_grain ? grain_next : grain_reg;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      read_block_enable_reg <= 1'b0;
      exec_block_enable_reg <= 1'b0;
    end else if (wr_grain) begin
      read_block_enable_reg <= cp_wdata_in[`GRAIN_READ_EN_BIT];
      exec_block_enable_reg <= cp_wdata_in[`GRAIN_EXEC_EN_BIT];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      grain_reg <= `GRAIN_MASK_RESET;
    end else if (wr_grain) begin
      grain_reg <= grain_next;
    end
  end

  // The inhibit bits of both translation-low words live here, so the
  // enable can drop writes at the source instead of masking later.
  for (genvar i = 0; i < 2; i++) begin : g_xlate
    always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
        rb_bit_reg[i] <= 1'b0;
        eb_bit_reg[i] <= 1'b0;
      end else if (wr_xlate[i]) begin
        if (read_block_enable_reg) begin
          rb_bit_reg[i] <= cp_wdata_in[`XLATE_READ_BLOCK_BIT];
        end
        if (exec_block_enable_reg) begin
          eb_bit_reg[i] <= cp_wdata_in[`XLATE_EXEC_BLOCK_BIT];
        end
      end
    end
    read_gate_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
      wr_xlate[i] && !read_block_enable_reg |=> rb_bit_reg[i] == $past(rb_bit_reg[i]))
      else $error("read-block bit changed while disabled");
    exec_gate_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
      wr_xlate[i] && !exec_block_enable_reg |=> eb_bit_reg[i] == $past(eb_bit_reg[i]))
      else $error("exec-block bit changed while disabled");
  end

  // Page-size select low bits only where not overridden.
  // A granularity write also clears bits it now overrides, which keeps
  // the stored copy consistent with what software can read.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      psz_reg <= '0;
    end else if (tlb_read_in) begin
      psz_reg <= {tlb_rd_psz_in[13:2], tlb_rd_psz_in[1:0] & ~load_mask};
    end else if (wr_psz) begin
      psz_reg <= {cp_wdata_in[`PSZ_HI:`PSZ_LO+2], cp_wdata_in[`PSZ_LO+1:`PSZ_LO] & ~grain_reg};
    end else if (wr_grain) begin
      psz_reg <= {psz_reg[13:2], psz_reg[1:0] & ~grain_next};
    end
  end

  // Page-pair number; TLB read wins over exception
  // and either wins over a software write in the same cycle.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      vpp_reg <= '0;
    end else if (tlb_read_in) begin
      vpp_reg <= {tlb_rd_vpp_in[20:2], tlb_rd_vpp_in[1:0] & ~load_mask};
    end else if (tlb_exc_in) begin
      vpp_reg <= {exc_vaddr_in[`VPP_HI:`VPP_LO+2], exc_vaddr_in[`VPP_LO+1:`VPP_LO] & ~load_mask};
    end else if (wr_mh) begin
      vpp_reg <= {cp_wdata_in[`VPP_HI:`VPP_LO+2], cp_wdata_in[`VPP_LO+1:`VPP_LO] & ~grain_reg};
    end else if (wr_grain) begin
      vpp_reg <= {vpp_reg[20:2], vpp_reg[1:0] & ~grain_next};
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      tag_reg <= '0;
    end else if (tlb_read_in) begin
      tag_reg <= tlb_rd_tag_in;
    end else if (wr_mh) begin
      tag_reg <= cp_wdata_in[`TAG_HI:`TAG_LO];
    end
  end

  // Read multiplexer; unmapped selections read as zero.
  always_comb begin
    rdata_next = '0;
    if (cp_num_in == `CP_NUM_PAGE_SIZE && cp_sel_in == `CP_SEL_GRAIN) begin
      rdata_next[`GRAIN_READ_EN_BIT] = read_block_enable_reg;
      rdata_next[`GRAIN_EXEC_EN_BIT] = exec_block_enable_reg;
      rdata_next[`GRAIN_MASK_HI:`GRAIN_MASK_LO] = grain_reg;
      rdata_next[`GRAIN_ONES_HI:`GRAIN_ONES_LO] = `GRAIN_ONES_VALUE;
    end else if (cp_num_in == `CP_NUM_PAGE_SIZE && cp_sel_in == `CP_SEL_PAGE_SIZE) begin
      rdata_next[`PSZ_HI:`PSZ_LO] = {psz_reg[13:2], psz_reg[1:0] & ~grain_reg};
    end else if (cp_num_in == `CP_NUM_MATCH_HIGH && cp_sel_in == `CP_SEL_MATCH_HIGH) begin
      rdata_next[`VPP_HI:`VPP_LO] = vpp_reg;
      rdata_next[`TAG_HI:`TAG_LO] = tag_reg;
    end else if (cp_num_in == `CP_NUM_CONFIG && cp_sel_in == `CP_SEL_CONFIG_THREE) begin
      rdata_next = `CFG3_OTHER_DEFAULT;
      rdata_next[`CFG3_PRESENT_BIT] = 1'b1;
    end else if (cp_num_in == `CP_NUM_XLATE_EVEN && cp_sel_in == `CP_SEL_XLATE) begin
      rdata_next[`XLATE_READ_BLOCK_BIT] = rb_bit_reg[0];
      rdata_next[`XLATE_EXEC_BLOCK_BIT] = eb_bit_reg[0];
    end else if (cp_num_in == `CP_NUM_XLATE_ODD && cp_sel_in == `CP_SEL_XLATE) begin
      rdata_next[`XLATE_READ_BLOCK_BIT] = rb_bit_reg[1];
      rdata_next[`XLATE_EXEC_BLOCK_BIT] = eb_bit_reg[1];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      cp_rdata_out <= '0;
      cp_rvalid_out <= 1'b0;
    end else begin
      cp_rvalid_out <= cp_rd_in;
      if (cp_rd_in) begin
        cp_rdata_out <= rdata_next;
      end
    end
  end

  // Outputs toward the TLB are registered copies (match_mask_out ORs grain_reg into psz_reg), so they trail the
  // registers by one cycle; a flush always precedes changes anyway.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      match_mask_out <= '0;
      virt_page_pair_number_out <= '0;
      addr_space_tag_out <= '0;
      grain_mask_out <= `GRAIN_MASK_RESET;
      read_block_enable_out <= 1'b0;
      exec_block_enable_out <= 1'b0;
      read_block_bit_out <= '0;
      exec_block_bit_out <= '0;
    end else begin
      match_mask_out <= {psz_reg[13:2], psz_reg[1:0] | grain_reg};
      virt_page_pair_number_out <= vpp_reg;
      addr_space_tag_out <= tag_reg;
      grain_mask_out <= grain_reg;
      read_block_enable_out <= read_block_enable_reg;
      exec_block_enable_out <= exec_block_enable_reg;
      read_block_bit_out <= rb_bit_reg;
      exec_block_bit_out <= eb_bit_reg;
    end
  end

  grain_fixed_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !IMPL_1K |-> grain_reg[0])
    else $error("unimplemented low mask bit not one");

  grain_follow_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !IMPL_2K |-> grain_reg[1] == grain_reg[0])
    else $error("unimplemented high mask bit not copied");

  grain_read_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    cp_rd_in && cp_num_in == `CP_NUM_PAGE_SIZE && cp_sel_in == `CP_SEL_GRAIN
    |=> cp_rvalid_out && cp_rdata_out[10:8] == 3'h7 && cp_rdata_out[29:13] == '0
        && cp_rdata_out[7:0] == '0)
    else $error("granularity reserved fields wrong");

  mask_match_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    grain_reg[0] && grain_reg[1] |=> match_mask_out[1:0] == 2'h3)
    else $error("overridden bits not excluded from match");

  vpp_low_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (vpp_reg[1:0] & grain_reg) == 2'h0 && (psz_reg[1:0] & grain_reg) == 2'h0)
    else $error("overridden low bit holds a one");

  exc_load_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    tlb_exc_in && !tlb_read_in |=> vpp_reg[20:2] == $past(exc_vaddr_in[31:13]))
    else $error("exception did not load page-pair");

  mh_read_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    cp_rd_in && cp_num_in == `CP_NUM_MATCH_HIGH && cp_sel_in == `CP_SEL_MATCH_HIGH
    |=> cp_rdata_out[10:8] == 3'h0 && cp_rdata_out[7:0] == $past(tag_reg))
    else $error("match-high read wrong");

  cfg3_flag_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    cp_rd_in && cp_num_in == `CP_NUM_CONFIG && cp_sel_in == `CP_SEL_CONFIG_THREE
    |=> cp_rdata_out[1])
    else $error("feature flag not set");

  mask_reset_a: assert property (@(posedge mclk_in)
    $rose(rst_n) |-> grain_reg == 2'h3 && !read_block_enable_reg && !exec_block_enable_reg)
    else $error("granularity reset value wrong");

  enable_write_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    wr_grain |=> read_block_enable_reg == $past(cp_wdata_in[`GRAIN_READ_EN_BIT])
      && exec_block_enable_reg == $past(cp_wdata_in[`GRAIN_EXEC_EN_BIT]))
    else $error("inhibit enable not written");

  full_mask_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    wr_grain && IMPL_1K && IMPL_2K
    |=> grain_reg == $past(cp_wdata_in[`GRAIN_MASK_HI:`GRAIN_MASK_LO]))
    else $error("mask not stored as written");

  // Subset parts fold the written mask before it is stored, so these
  // checks compare against the written bits one edge back.
  // 2K-only folding.
  fold_2k_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    wr_grain && !IMPL_1K && IMPL_2K
    |=> grain_reg == {$past(cp_wdata_in[`GRAIN_MASK_HI]), 1'b1})
    else $error("2K-only mask folding wrong");

  fold_1k_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    wr_grain && IMPL_1K && !IMPL_2K
    |=> grain_reg == {2{$past(cp_wdata_in[`GRAIN_MASK_LO])}})
    else $error("1K-only mask folding wrong");

  psz_read_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    cp_rd_in && cp_num_in == `CP_NUM_PAGE_SIZE && cp_sel_in == `CP_SEL_PAGE_SIZE
    |=> (cp_rdata_out[12:11] & $past(grain_reg)) == 2'h0 && cp_rdata_out[31:25] == '0
        && cp_rdata_out[10:0] == '0)
    else $error("page-size read shows overridden bits");

  tlb_load_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    tlb_read_in |=> vpp_reg[20:2] == $past(tlb_rd_vpp_in[20:2])
      && tag_reg == $past(tlb_rd_tag_in) && psz_reg[13:2] == $past(tlb_rd_psz_in[13:2]))
    else $error("TLB read did not load match fields");

  out_lag_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    grain_mask_out == $past(grain_reg) && virt_page_pair_number_out == $past(vpp_reg))
    else $error("TLB-facing copies out of step");

endmodule // page_grain_ctl
`default_nettype wire

// >>> tb/page_grain_ctl_tb.sv
// Self-checking testbench for the page granularity control block.
`default_nettype none
`include "page_grain_cfg.svh"
module page_grain_ctl_tb import page_grain_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in, rst_n_in, cp_wr, cp_rd, tlb_exc, tlb_read, rvalid, rbe, xbe;
  cp_num_t num;
  cp_sel_t sel;
  cp_word_t wdata, rdata, rdata2, rdata3, vaddr;
  vpp_t rd_vpp, vpp_o;
  tag_t rd_tag, tag_o;
  psz_mask_t rd_psz, mm_o;
  grain_mask_t gm_o;
  logic [1:0] rbb, xbb;
  int fails, checked;

  page_grain_ctl DUT (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .cp_wr_in(cp_wr), .cp_rd_in(cp_rd),
    .cp_num_in(num), .cp_sel_in(sel), .cp_wdata_in(wdata), .cp_rdata_out(rdata),
    .cp_rvalid_out(rvalid), .tlb_exc_in(tlb_exc), .exc_vaddr_in(vaddr),
    .tlb_read_in(tlb_read), .tlb_rd_vpp_in(rd_vpp), .tlb_rd_tag_in(rd_tag),
    .tlb_rd_psz_in(rd_psz), .match_mask_out(mm_o), .virt_page_pair_number_out(vpp_o),
    .addr_space_tag_out(tag_o), .grain_mask_out(gm_o), .read_block_enable_out(rbe),
    .exec_block_enable_out(xbe), .read_block_bit_out(rbb), .exec_block_bit_out(xbb));

  // A part without 1K pages shares every input with the full part.
  page_grain_ctl #(.IMPL_1K(1'b0), .IMPL_2K(1'b1)) sub_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .cp_wr_in(cp_wr), .cp_rd_in(cp_rd),
    .cp_num_in(num), .cp_sel_in(sel), .cp_wdata_in(wdata), .cp_rdata_out(rdata2),
    .cp_rvalid_out(), .tlb_exc_in(tlb_exc), .exc_vaddr_in(vaddr),
    .tlb_read_in(tlb_read), .tlb_rd_vpp_in(rd_vpp), .tlb_rd_tag_in(rd_tag),
    .tlb_rd_psz_in(rd_psz), .match_mask_out(), .virt_page_pair_number_out(),
    .addr_space_tag_out(), .grain_mask_out(), .read_block_enable_out(),
    .exec_block_enable_out(), .read_block_bit_out(), .exec_block_bit_out());

  // A part without 2K pages, on the same inputs again.
  page_grain_ctl #(.IMPL_1K(1'b1), .IMPL_2K(1'b0)) sub_1k (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .cp_wr_in(cp_wr), .cp_rd_in(cp_rd),
    .cp_num_in(num), .cp_sel_in(sel), .cp_wdata_in(wdata), .cp_rdata_out(rdata3),
    .cp_rvalid_out(), .tlb_exc_in(tlb_exc), .exc_vaddr_in(vaddr),
    .tlb_read_in(tlb_read), .tlb_rd_vpp_in(rd_vpp), .tlb_rd_tag_in(rd_tag),
    .tlb_rd_psz_in(rd_psz), .match_mask_out(), .virt_page_pair_number_out(),
    .addr_space_tag_out(), .grain_mask_out(), .read_block_enable_out(),
    .exec_block_enable_out(), .read_block_bit_out(), .exec_block_bit_out());

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input cp_num_t n, input cp_sel_t s, input cp_word_t d);
    @(posedge mclk_in);
    cp_wr <= 1'b1;
    num <= n;
    sel <= s;
    wdata <= d;
    @(posedge mclk_in);
    cp_wr <= 1'b0;
  endtask

  // The read answer is registered, so it is judged just after the taking edge.
  task automatic rd_chk(input cp_num_t n, input cp_sel_t s, input cp_word_t exp);
    @(posedge mclk_in);
    cp_rd <= 1'b1;
    num <= n;
    sel <= s;
    @(posedge mclk_in);
    cp_rd <= 1'b0;
    #1;
    check(rvalid, 1, "read valid");
    check(rdata, exp, "read data");
  endtask

  task automatic hw(input logic e, input logic r);
    @(posedge mclk_in);
    tlb_exc <= e;
    tlb_read <= r;
    @(posedge mclk_in);
    tlb_exc <= 1'b0;
    tlb_read <= 1'b0;
  endtask

  function automatic cp_word_t grain_word(input logic [1:0] m);
    return {19'h0, m, 3'h7, 8'h0};
  endfunction

  task automatic test_reset();
    rd_chk(`CP_NUM_PAGE_SIZE, `CP_SEL_GRAIN, 32'h0000_1f00);
    check(gm_o, 2'h3, "reset mask");
    check({rbe, xbe}, 2'h0, "reset enables");
    rd_chk(`CP_NUM_CONFIG, `CP_SEL_CONFIG_THREE, `CFG3_OTHER_DEFAULT | 32'h2);
    rd_chk(`CP_NUM_MATCH_HIGH, `CP_SEL_MATCH_HIGH, 32'h0);
    $display("test_reset done");
  endtask

  task automatic test_inhibit();
    wr(`CP_NUM_XLATE_EVEN, `CP_SEL_XLATE, 32'hc000_0000);
    rd_chk(`CP_NUM_XLATE_EVEN, `CP_SEL_XLATE, 32'h0);
    wr(`CP_NUM_PAGE_SIZE, `CP_SEL_GRAIN, 32'hc000_1f00);
    wr(`CP_NUM_XLATE_ODD, `CP_SEL_XLATE, 32'h4000_0000);
    wr(`CP_NUM_XLATE_EVEN, `CP_SEL_XLATE, 32'h8000_0000);
    rd_chk(`CP_NUM_XLATE_EVEN, `CP_SEL_XLATE, 32'h8000_0000);
    rd_chk(`CP_NUM_XLATE_ODD, `CP_SEL_XLATE, 32'h4000_0000);
    check({rbe, xbe, rbb, xbb}, 6'b11_01_10, "inhibit outputs");
    wr(`CP_NUM_PAGE_SIZE, `CP_SEL_GRAIN, 32'h0000_1f00);
    rd_chk(`CP_NUM_PAGE_SIZE, `CP_SEL_GRAIN, 32'h0000_1f00);
    $display("test_inhibit done");
  endtask

  task automatic test_grain();
    grain_mask_t modes[3] = '{2'h0, 2'h1, 2'h3};
    foreach (modes[i]) begin
      // No TLB entry is ever valid here, so every mask change follows a flush.
      wr(`CP_NUM_PAGE_SIZE, `CP_SEL_GRAIN, grain_word(modes[i]));
      wr(`CP_NUM_PAGE_SIZE, `CP_SEL_PAGE_SIZE, 32'h0180_1800);
      wr(`CP_NUM_MATCH_HIGH, `CP_SEL_MATCH_HIGH, 32'hffff_f85a);
      rd_chk(`CP_NUM_PAGE_SIZE, `CP_SEL_GRAIN, grain_word(modes[i]));
      rd_chk(`CP_NUM_PAGE_SIZE, `CP_SEL_PAGE_SIZE, {7'h0, 12'hc00, ~modes[i], 11'h0});
      rd_chk(`CP_NUM_MATCH_HIGH, `CP_SEL_MATCH_HIGH, {19'h7ffff, ~modes[i], 11'h05a});
      check(gm_o, modes[i], "mask output");
      check(vpp_o, {19'h7ffff, ~modes[i]}, "page pair output");
      check(tag_o, 8'h5a, "tag output");
      wr(`CP_NUM_PAGE_SIZE, `CP_SEL_PAGE_SIZE, 32'h0180_0000);
      rd_chk(`CP_NUM_PAGE_SIZE, `CP_SEL_PAGE_SIZE, 32'h0180_0000);
      check(mm_o, {2'h3, 10'h0, modes[i]}, "match mask");
    end
    $display("test_grain done");
  endtask

  task automatic test_hw_load(input grain_mask_t m);
    wr(`CP_NUM_PAGE_SIZE, `CP_SEL_GRAIN, grain_word(m));
    wr(`CP_NUM_MATCH_HIGH, `CP_SEL_MATCH_HIGH, 32'h0000_0033);
    hw(1'b1, 1'b0);
    rd_chk(`CP_NUM_MATCH_HIGH, `CP_SEL_MATCH_HIGH, {vaddr[31:13], vaddr[12:11] & ~m, 11'h033});
    hw(1'b1, 1'b1);
    rd_chk(`CP_NUM_MATCH_HIGH, `CP_SEL_MATCH_HIGH, {rd_vpp[20:2], rd_vpp[1:0] & ~m, 11'h077});
    check(vpp_o, {rd_vpp[20:2], rd_vpp[1:0] & ~m}, "loaded page pair");
    rd_chk(`CP_NUM_PAGE_SIZE, `CP_SEL_PAGE_SIZE, {7'h0, 12'hfff, ~m, 11'h0});
    $display("test_hw_load done");
  endtask

  task automatic test_subset();
    logic [1:0] exp2[4] = '{2'h1, 2'h1, 2'h3, 2'h3};
    logic [1:0] exp3[4] = '{2'h0, 2'h3, 2'h0, 2'h3};
    for (int i = 0; i < 4; i++) begin
      wr(`CP_NUM_PAGE_SIZE, `CP_SEL_GRAIN, grain_word(i[1:0]));
      rd_chk(`CP_NUM_PAGE_SIZE, `CP_SEL_GRAIN, grain_word(i[1:0]));
      check(rdata2, grain_word(exp2[i]), "subset readback");
      check(rdata3, grain_word(exp3[i]), "1K-only readback");
    end
    $display("test_subset done");
  endtask

  task automatic report_and_stop();
    $display("Counts: %0d comparisons, %0d mismatches", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk_in);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    {rst_n_in, cp_wr, cp_rd, tlb_exc, tlb_read} = 5'h0;
    {num, sel, wdata} = '0;
    vaddr = 32'hdead_b8f3;
    rd_vpp = 21'h0a5a7;
    rd_tag = 8'h77;
    rd_psz = 14'h3fff;
    fails = 0;
    checked = 0;
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    test_reset();
    test_inhibit();
    test_grain();
    test_hw_load(2'h0);
    test_hw_load(2'h3);
    test_subset();
    report_and_stop();
  end
endmodule // page_grain_ctl_tb
`default_nettype wire
